// ===== src/lcus_params.svh
// constants for the config unlock gate and serial interrupt slave
// assumes one system clock domain; link clock arrives as a sampled input
// Summary of operation
// - 55h to index port enters unlock
// - index and data ports act only unlocked
// - any reset clears unlock state
// - AAh to index port leaves unlock
// - base register 60h relocates config port
// - all frame channels disabled after reset; the irq2 frame still carries smi
// - quiet start: one low clock, no high
// - no start pulse during active cycle
// - quiet: level change requests a start
// - continuous mode: slave never starts cycle
// - mode changes in stop; resets continuous
// - stop width two quiet, three continuous
// - frames of three clocks after rising edge
// - sample clock low only for low level
// - recovery high after own low; turnaround off
// - frame N samples at 3N-1 clocks
// - present levels whoever started the cycle
// - IRQ13 in period 14, selectable
// - idle in stop ok; back-to-back start
// - host stops; start two clocks after stop
// - link reset tri-states line, continuous mode
// - drive and sample on link clock rises
// - one routed source per frame
`ifndef LCUS_PARAMS_SVH
`define LCUS_PARAMS_SVH
`define LCUS_KEY_ENTER    8'h55
`define LCUS_KEY_EXIT     8'hAA
`define LCUS_IDX_BASE_HI  8'h60
`define LCUS_IDX_BASE_LO  8'h61
`define LCUS_IDX_ROUTE    4'h4
`define LCUS_ROUTE_EN     7
`define LCUS_ROUTE_RST    8'h00
`define LCUS_PH_RECOV     2'h0
`define LCUS_PH_TURN      2'h1
`define LCUS_PH_SAMPLE    2'h2
`define LCUS_NFRAMES      5'h10
`define LCUS_IRQ2_FRAME   2
`define LCUS_STOP_MIN     3'h2
`define LCUS_STOP_QUIET   3'h2
`define LCUS_STOP_CONT    3'h3
`define LCUS_HOLDOFF      2'h1
`define LCUS_REG_STATUS   8'h00
`define LCUS_REG_CTRL     8'h04
`define LCUS_REG_BASE     8'h08
`define LCUS_ST_UNLOCK    0
`define LCUS_ST_QUIET     1
`define LCUS_ST_ACTIVE    2
`define LCUS_ST_PENDING   3
`define LCUS_CTRL_SMIMASK 0
`endif

// ===== src/lcus_pkg.sv
// types shared by the unlock gate and serial interrupt slave
// assumes the params header is included by users of the constants
package lcus_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        wr;
    logic        rd;
  } lcus_io_req_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } lcus_bus_req_s;

  typedef enum logic [4:0] {
    SL_IDLE   = 5'b00001,
    SL_OWNST  = 5'b00010,
    SL_START  = 5'b00100,
    SL_FRAMES = 5'b01000,
    SL_STOP   = 5'b10000
  } lcus_slave_state_e;
endpackage : lcus_pkg

// ===== src/lcus_top.sv
// config port unlock gate and serial interrupt slave
// assumes host io cycles already decoded to byte strobes on clock;
// link clock, serial irq line and resets arrive asynchronous
//
// Added by the designer: the placing of the registers and the plain strobed port.
`include "lcus_params.svh"
module lcus_top #(
  parameter int          NSRC             = 16,
  parameter logic [15:0] CFG_BASE_DEFAULT = 16'h002E
) (
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  input  wire logic                   systemReset_n,
  input  wire logic                   legacyIoReset_n,
  input  wire logic                   linkReset_n,
  input  wire logic                   lpcClock,
  input  wire logic                   serialIrqPinIn,
  output logic                        serialIrqPinOut,
  output logic                        serialIrqPinOe_n,
  input  wire lcus_pkg::lcus_io_req_s ioReq,
  output logic [7:0]                  ioRdData,
  input  wire lcus_pkg::lcus_bus_req_s busReq,
  output logic [31:0]                 busRdData,
  input  wire logic [NSRC-1:0]        srcIrq,
  input  wire logic                   legacySmiRequest
);
  localparam int SELW = (NSRC > 1) ? $clog2(NSRC) : 1;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [4:0] syncA_r;
  logic [4:0] syncB_r;
  logic       lclkPrev_r;
  wire  [4:0] rawIn = {lpcClock, serialIrqPinIn, systemReset_n, legacyIoReset_n, linkReset_n};

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      syncA_r    <= 5'h08;
      syncB_r    <= 5'h08;
      lclkPrev_r <= 1'b0;
    end else begin
      syncA_r    <= rawIn;
      syncB_r    <= syncA_r;
      lclkPrev_r <= syncB_r[4];
    end
  end

  wire lclkS   = syncB_r[4];
  wire pinIn   = syncB_r[3];
  wire sysRstS = ~syncB_r[2];
  wire ioRstS  = ~syncB_r[1];
  wire lnkRstS = ~syncB_r[0];
  // every line decision but link reset waits for a seen link clock rise
  wire tick    = lclkS & ~lclkPrev_r;
  wire anyRst  = sysRstS | ioRstS | lnkRstS;

  // ---------------------------------------------------------------
  // configuration port
  // ---------------------------------------------------------------
  logic        unlock_r;
  logic [7:0]  index_r;
  logic [15:0] base_r;
  logic [7:0]  route_r [16];
  logic        smiMask_r;

  wire hitIndex = ioReq.addr == base_r;
  wire hitData  = ioReq.addr == 16'(base_r + 16'h0001);
  wire idxWr    = ioReq.wr & hitIndex;
  wire dataWr   = ioReq.wr & hitData & unlock_r;
  wire keyIn    = idxWr & ~unlock_r & (ioReq.data == `LCUS_KEY_ENTER);
  wire keyOut   = idxWr & unlock_r & (ioReq.data == `LCUS_KEY_EXIT);
  wire idxLoad  = idxWr & unlock_r & ~keyOut;
  wire isRoute  = index_r[7:4] == `LCUS_IDX_ROUTE;

  function automatic logic [7:0] cfgRead(input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx == `LCUS_IDX_BASE_HI) begin
      v = base_r[15:8];
    end else if (idx == `LCUS_IDX_BASE_LO) begin
      v = base_r[7:0];
    end else if (idx[7:4] == `LCUS_IDX_ROUTE) begin
      v = route_r[idx[3:0]];
    end
    return v;
  endfunction : cfgRead

  // locked reads give zero: data is undefined then anyway
  wire [7:0] ioRdNxt = !(ioReq.rd & unlock_r) ? 8'h00 :
                       hitIndex ? index_r :
                       hitData  ? cfgRead(index_r) : 8'h00;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      unlock_r <= 1'b0;
    end else if (anyRst | keyOut) begin
      unlock_r <= 1'b0;
    end else if (keyIn) begin
      unlock_r <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      index_r  <= 8'h00;
      base_r   <= CFG_BASE_DEFAULT;
      ioRdData <= 8'h00;
    end else begin
      ioRdData <= ioRdNxt;
      if (idxLoad) begin
        index_r <= ioReq.data;
      end
      if (dataWr && index_r == `LCUS_IDX_BASE_HI) begin
        base_r[15:8] <= ioReq.data;
      end
      if (dataWr && index_r == `LCUS_IDX_BASE_LO) begin
        base_r[7:0] <= ioReq.data;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : gRoute
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          route_r[g] <= `LCUS_ROUTE_RST;
        end else if (dataWr && isRoute && index_r[3:0] == 4'(g)) begin
          route_r[g] <= ioReq.data;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // frame levels
  // ---------------------------------------------------------------
  logic [15:0] lvl_r;
  logic [15:0] lvlNxt;

  generate
    for (g = 0; g < 16; g++) begin : gLvl
      wire [SELW-1:0] sel = route_r[g][SELW-1:0];
      wire            en  = route_r[g][`LCUS_ROUTE_EN];
      // a single select per frame keeps two sources off one frame
      wire srcLvl = (32'(sel) < NSRC) ? srcIrq[sel] : 1'b1;
      if (g == `LCUS_IRQ2_FRAME) begin : gShared
        // the route enable keeps irq2 routing and smi exclusive
        assign lvlNxt[g] = en ? srcLvl : (smiMask_r | legacySmiRequest);
      end else begin : gPlain
        assign lvlNxt[g] = en ? srcLvl : 1'b1;
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lvl_r <= 16'hFFFF;
    end else begin
      lvl_r <= lvlNxt;
    end
  end

  // ---------------------------------------------------------------
  // serial interrupt slave
  // ---------------------------------------------------------------
  lcus_pkg::lcus_slave_state_e st_r;
  lcus_pkg::lcus_slave_state_e st_nxt;
  logic        quiet_r;
  logic        quiet_nxt;
  logic [1:0]  ph_r;
  logic [1:0]  ph_nxt;
  logic [4:0]  fIdx_r;
  logic [4:0]  fIdx_nxt;
  logic [2:0]  lowCnt_r;
  logic [2:0]  lowCnt_nxt;
  logic [1:0]  hold_r;
  logic [1:0]  hold_nxt;
  logic [15:0] sent_r;
  logic        drvLow_r;
  logic        drvLow_nxt;
  logic        drvHigh_r;
  logic        drvHigh_nxt;

  wire [2:0] lowInc  = (lowCnt_r == 3'h7) ? lowCnt_r : 3'(lowCnt_r + 3'h1);
  wire       pending = lvl_r != sent_r;
  wire       inFrame = fIdx_r < `LCUS_NFRAMES;
  wire [3:0] fSel    = fIdx_r[3:0];
  wire       canStart = quiet_r & pending & (hold_r == 2'h0);

  always_comb begin
    st_nxt      = st_r;
    quiet_nxt   = quiet_r;
    ph_nxt      = ph_r;
    fIdx_nxt    = fIdx_r;
    lowCnt_nxt  = pinIn ? 3'h0 : lowInc;
    hold_nxt    = (hold_r == 2'h0) ? hold_r : 2'(hold_r - 2'h1);
    drvLow_nxt  = 1'b0;
    drvHigh_nxt = 1'b0;
    unique case (st_r)
      lcus_pkg::SL_IDLE: begin
        if (!pinIn) begin
          st_nxt = lcus_pkg::SL_START;
        end else if (canStart) begin
          st_nxt     = lcus_pkg::SL_OWNST;
          drvLow_nxt = 1'b1;
        end
      end
      lcus_pkg::SL_OWNST: begin
        // released after one clock, never driven high
        st_nxt = lcus_pkg::SL_START;
      end
      lcus_pkg::SL_START: begin
        if (pinIn) begin
          st_nxt   = lcus_pkg::SL_FRAMES;
          ph_nxt   = `LCUS_PH_RECOV;
          fIdx_nxt = 5'h00;
        end
      end
      lcus_pkg::SL_FRAMES: begin
        ph_nxt = (ph_r == `LCUS_PH_SAMPLE) ? `LCUS_PH_RECOV : 2'(ph_r + 2'h1);
        if (ph_r == `LCUS_PH_SAMPLE && inFrame) begin
          fIdx_nxt = 5'(fIdx_r + 5'h01);
        end
        if (!pinIn && lowInc >= `LCUS_STOP_MIN) begin
          st_nxt = lcus_pkg::SL_STOP;
        end else if (ph_nxt == `LCUS_PH_SAMPLE && fIdx_nxt < `LCUS_NFRAMES) begin
          drvLow_nxt = ~lvl_r[fIdx_nxt[3:0]];
        end else if (ph_nxt == `LCUS_PH_RECOV) begin
          drvHigh_nxt = drvLow_r;
        end
      end
      lcus_pkg::SL_STOP: begin
        if (pinIn) begin
          st_nxt   = lcus_pkg::SL_IDLE;
          hold_nxt = `LCUS_HOLDOFF;
          if (lowCnt_r == `LCUS_STOP_QUIET) begin
            quiet_nxt = 1'b1;
          end else if (lowCnt_r == `LCUS_STOP_CONT) begin
            quiet_nxt = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_r      <= lcus_pkg::SL_IDLE;
      quiet_r   <= 1'b0;
      ph_r      <= `LCUS_PH_RECOV;
      fIdx_r    <= 5'h00;
      lowCnt_r  <= 3'h0;
      hold_r    <= 2'h0;
      drvLow_r  <= 1'b0;
      drvHigh_r <= 1'b0;
    end else if (lnkRstS) begin
      st_r      <= lcus_pkg::SL_IDLE;
      quiet_r   <= 1'b0;
      ph_r      <= `LCUS_PH_RECOV;
      fIdx_r    <= 5'h00;
      lowCnt_r  <= 3'h0;
      hold_r    <= 2'h0;
      drvLow_r  <= 1'b0;
      drvHigh_r <= 1'b0;
    end else if (tick) begin
      st_r      <= st_nxt;
      quiet_r   <= quiet_nxt;
      ph_r      <= ph_nxt;
      fIdx_r    <= fIdx_nxt;
      lowCnt_r  <= lowCnt_nxt;
      hold_r    <= hold_nxt;
      drvLow_r  <= drvLow_nxt;
      drvHigh_r <= drvHigh_nxt;
    end
  end

  // levels count as delivered once their sample clock passes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sent_r <= 16'hFFFF;
    end else if (lnkRstS) begin
      sent_r <= 16'hFFFF;
    end else if (tick && st_r == lcus_pkg::SL_FRAMES && ph_r == `LCUS_PH_SAMPLE && inFrame) begin
      sent_r[fSel] <= ~drvLow_r;
    end
  end

  assign serialIrqPinOut  = drvHigh_r;
  assign serialIrqPinOe_n = ~(drvLow_r | drvHigh_r);

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  wire selStatus = busReq.addr == `LCUS_REG_STATUS;
  wire selCtrl   = busReq.addr == `LCUS_REG_CTRL;
  wire selBase   = busReq.addr == `LCUS_REG_BASE;
  wire active    = st_r != lcus_pkg::SL_IDLE;

  wire [31:0] statusWord = {28'h0000000, pending, active, quiet_r, unlock_r};
  wire [31:0] rdMux = selStatus ? statusWord :
                      selCtrl   ? {31'h00000000, smiMask_r} :
                      selBase   ? {16'h0000, base_r} : 32'h00000000;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      smiMask_r <= 1'b0;
      busRdData <= 32'h00000000;
    end else begin
      busRdData <= busReq.rd ? rdMux : 32'h00000000;
      if (busReq.wr && selCtrl) begin
        smiMask_r <= busReq.wdata[`LCUS_CTRL_SMIMASK];
      end
    end
  end
endmodule : lcus_top

// ===== sim/lcus_checker.sv
// port assertions for lcus_top
// assumes the bench's 400 ns link clock against a 50 ns system clock
`include "lcus_params.svh"
module lcus_checker (
  input wire logic                    clock,
  input wire logic                    reset_n,
  input wire logic                    systemReset_n,
  input wire logic                    legacyIoReset_n,
  input wire logic                    linkReset_n,
  input wire logic                    serialIrqPinOut,
  input wire logic                    serialIrqPinOe_n,
  input wire lcus_pkg::lcus_io_req_s  ioReq,
  input wire logic [7:0]              ioRdData,
  input wire lcus_pkg::lcus_bus_req_s busReq,
  input wire logic [31:0]             busRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ----
  // serial line
  // ----
  property p_link_tri;
    !linkReset_n [*6] |-> serialIrqPinOe_n;
  endproperty
  a_link_tri: assert property (p_link_tri) else $error("line driven in link reset");
  property p_drive_holds;
    $fell(serialIrqPinOe_n) |=> !serialIrqPinOe_n [*6];
  endproperty
  a_drive_holds: assert property (p_drive_holds) else $error("drive shorter than a link clock");
  property p_high_after_low;
    $rose(serialIrqPinOut) |-> !serialIrqPinOe_n && !$past(serialIrqPinOut) && !$past(serialIrqPinOe_n);
  endproperty
  a_high_after_low: assert property (p_high_after_low) else $error("high without own low");
  property p_high_one_tick;
    $rose(serialIrqPinOut) |-> serialIrqPinOut [*6] ##[1:4] serialIrqPinOe_n;
  endproperty
  a_high_one_tick: assert property (p_high_one_tick) else $error("no turnaround release");
  // ----
  // access ports
  // ----
  property p_io_idle;
    !$past(ioReq.rd) |-> ioRdData == 8'h00;
  endproperty
  a_io_idle: assert property (p_io_idle) else $error("io data without read");
  property p_bus_idle;
    !$past(busReq.rd) |-> busRdData == 32'h0;
  endproperty
  a_bus_idle: assert property (p_bus_idle) else $error("bus data without read");
  property p_sys_lock;
    !systemReset_n [*5] ##0 (busReq.rd && busReq.addr == `LCUS_REG_STATUS) |=> !busRdData[`LCUS_ST_UNLOCK];
  endproperty
  a_sys_lock: assert property (p_sys_lock) else $error("unlocked in system reset");
  property p_legacy_lock;
    !legacyIoReset_n [*5] ##0 (busReq.rd && busReq.addr == `LCUS_REG_STATUS) |=> !busRdData[`LCUS_ST_UNLOCK];
  endproperty
  a_legacy_lock: assert property (p_legacy_lock) else $error("unlocked in io reset");
endmodule : lcus_checker
bind lcus_top lcus_checker chk_u (
  .clock(clock), .reset_n(reset_n), .systemReset_n(systemReset_n), .legacyIoReset_n(legacyIoReset_n),
  .linkReset_n(linkReset_n), .serialIrqPinOut(serialIrqPinOut), .serialIrqPinOe_n(serialIrqPinOe_n),
  .ioReq(ioReq), .ioRdData(ioRdData), .busReq(busReq), .busRdData(busRdData)
);

// ===== sim/lcus_host_model.sv
// host controller model: link clock and serial irq master
// assumes a pull-up on the line; link clock runs free
module lcus_host_model (
  input  wire logic  devOut,
  input  wire logic  devOe_n,
  output logic       lpcClock,
  output logic       line,
  output logic [15:0] samples
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hostOe = 1'b0;
  logic hostVal = 1'b1;
  // odd offset keeps link edges off system clock edges
  initial begin
    lpcClock = 1'b0;
    samples = '1;
    #7;
    forever #200 lpcClock = ~lpcClock;
  end
  assign line = !devOe_n ? devOut : (hostOe ? hostVal : 1'b1);
  // ----
  // one cycle: start, 16 frames, stop
  // ----
  task automatic run_cycle(input int stopLow, input bit fromDev);
    int c;
    hostOe <= 1'b1;
    hostVal <= 1'b0;
    repeat (fromDev ? 3 : 4) @(posedge lpcClock);
    hostVal <= 1'b1;
    samples = '1;
    for (c = 0; c < 50; c++) begin
      @(posedge lpcClock);
      hostOe <= 1'b0;
      // frame f seen only at c = 3f+2; a late drive reads as high
      if (c >= 2 && (c - 2) % 3 == 0 && line === 1'b0) samples[(c - 2) / 3] = 1'b0;
    end
    hostOe <= 1'b1;
    hostVal <= 1'b0;
    repeat (stopLow) @(posedge lpcClock);
    hostVal <= 1'b1;
    @(posedge lpcClock);
    hostOe <= 1'b0;
    @(posedge lpcClock);
  endtask : run_cycle
  task automatic wait_start(output bit seen);
    int n;
    seen = 1'b0;
    for (n = 0; n < 200 && !seen; n++) begin
      @(posedge lpcClock);
      seen = (line === 1'b0);
    end
  endtask : wait_start
endmodule : lcus_host_model

// ===== sim/tb_top.sv
// self-checking bench for lcus_top with the host model
// assumes design files and checker compiled first
`include "lcus_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic systemReset_n = 1'b1;
  logic legacyIoReset_n = 1'b1;
  logic linkReset_n = 1'b0;
  logic legacySmiRequest = 1'b0;
  logic [15:0] srcIrq = '0;
  logic [15:0] cfgBase;
  logic [15:0] samples;
  logic [31:0] rdv;
  logic [31:0] busRdData;
  logic [7:0] ioRdData;
  logic lpcClock, line, devOut, devOe_n;
  lcus_pkg::lcus_io_req_s ioReq = '0;
  lcus_pkg::lcus_bus_req_s busReq = '0;
  int seed, k, cycles = 0, nErrors = 0, checkCount = 0;
  bit seen;
  always #25 clock = ~clock;
  lcus_top #(.NSRC(16)) dut_u (
    .clock(clock), .reset_n(reset_n), .systemReset_n(systemReset_n), .legacyIoReset_n(legacyIoReset_n),
    .linkReset_n(linkReset_n), .lpcClock(lpcClock), .serialIrqPinIn(line), .serialIrqPinOut(devOut),
    .serialIrqPinOe_n(devOe_n), .ioReq(ioReq), .ioRdData(ioRdData), .busReq(busReq),
    .busRdData(busRdData), .srcIrq(srcIrq), .legacySmiRequest(legacySmiRequest)
  );
  lcus_host_model host_u (
    .devOut(devOut), .devOe_n(devOe_n), .lpcClock(lpcClock), .line(line), .samples(samples)
  );
  // ----
  // helpers
  // ----
  task automatic chk(input logic [31:0] seenV, input logic [31:0] expV);
    checkCount++;
    if (seenV !== expV) begin
      nErrors++;
      $display("BAD at %0t: saw %0h expected %0h", $time, seenV, expV);
    end
  endtask : chk
  // entered at a rising edge; read data caught mid-cycle after the take edge
  task automatic acc(input bit isIo, input logic [15:0] a, input logic [31:0] d, input logic w);
    if (isIo) ioReq <= '{a, d[7:0], w, !w};
    else busReq <= '{a[7:0], d, w, !w};
    @(posedge clock);
    ioReq.wr <= 1'b0;
    ioReq.rd <= 1'b0;
    busReq.wr <= 1'b0;
    busReq.rd <= 1'b0;
    @(negedge clock);
    rdv = isIo ? {24'h0, ioRdData} : busRdData;
    @(posedge clock);
  endtask : acc
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      nErrors++;
      tally_and_finish();
    end
  end
  // ----
  // sequence
  // ----
  initial begin
    seed = 51;
    cfgBase = 16'h002E;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    linkReset_n <= 1'b1;
    repeat (4) @(posedge clock);
    host_u.run_cycle(3, 1'b0);
    chk(samples, 16'hFFFB);
    @(posedge clock);
    acc(0, `LCUS_REG_STATUS, 0, 0);
    chk(rdv[1:0], 2'b00);
    acc(0, 8'hFC, 32'hFFFF_FFFF, 1);
    acc(0, 8'hFC, 0, 0);
    chk(rdv, 0);
    acc(0, `LCUS_REG_CTRL, 32'h1, 1);
    acc(0, `LCUS_REG_CTRL, 0, 0);
    chk(rdv, 32'h1);
    acc(1, cfgBase + 16'h1, 0, 0);
    chk(rdv, 0);
    acc(1, cfgBase, 8'hAA, 1);
    acc(1, cfgBase, `LCUS_KEY_ENTER, 1);
    acc(1, cfgBase, `LCUS_KEY_ENTER, 1);
    acc(1, cfgBase, 0, 0);
    chk(rdv, 32'h55);
    acc(1, cfgBase, `LCUS_IDX_BASE_LO, 1);
    acc(1, cfgBase + 16'h1, 8'h34, 1);
    cfgBase = 16'h0034;
    acc(1, cfgBase, `LCUS_IDX_BASE_HI, 1);
    acc(1, cfgBase + 16'h1, 8'h12, 1);
    cfgBase = 16'h1234;
    acc(0, `LCUS_REG_BASE, 0, 0);
    chk(rdv, 32'h1234);
    for (k = 0; k < 16; k++) begin
      acc(1, cfgBase, 8'h40 + 8'(k), 1);
      acc(1, cfgBase + 16'h1, 8'h80 | 8'(k), 1);
    end
    acc(1, cfgBase, `LCUS_KEY_EXIT, 1);
    acc(1, 16'h002E, `LCUS_KEY_ENTER, 1);
    acc(1, cfgBase, 0, 0);
    chk(rdv, 0);
    for (k = 0; k < 4; k++) begin
      @(posedge clock);
      srcIrq <= (k == 0) ? 16'h0000 : (k == 1) ? 16'hFFFF : 16'($random(seed));
      legacySmiRequest <= 1'($random(seed));
      host_u.run_cycle(3, 1'b0);
      chk(samples, srcIrq);
    end
    @(posedge clock);
    srcIrq <= ~srcIrq;
    host_u.wait_start(seen);
    chk(seen, 0);
    host_u.run_cycle(2, 1'b0);
    chk(samples, srcIrq);
    @(posedge clock);
    acc(0, `LCUS_REG_STATUS, 0, 0);
    chk(rdv[1], 1);
    srcIrq <= srcIrq ^ 16'h2000;
    host_u.wait_start(seen);
    chk(seen, 1);
    if (seen) host_u.run_cycle(3, 1'b1);
    chk(samples, srcIrq);
    for (k = 0; k < 3; k++) begin
      @(posedge clock);
      acc(0, `LCUS_REG_BASE, 0, 0);
      cfgBase = rdv[15:0];
      acc(1, cfgBase, `LCUS_KEY_ENTER, 1);
      acc(0, `LCUS_REG_STATUS, 0, 0);
      chk(rdv[0], 1);
      systemReset_n <= (k != 0);
      legacyIoReset_n <= (k != 1);
      linkReset_n <= (k != 2);
      repeat (6) @(posedge clock);
      acc(0, `LCUS_REG_STATUS, 0, 0);
      systemReset_n <= 1'b1;
      legacyIoReset_n <= 1'b1;
      linkReset_n <= 1'b1;
      chk(rdv[0], 0);
    end
    tally_and_finish();
  end
endmodule : tb_top
